// *** hdl/elpc_pkg.sv ***
package elpc_pkg;

    // Register byte addresses on the APB
    localparam logic [7:0] ADDR_STATUS_ONE   = 8'h00;
    localparam logic [7:0] ADDR_STATUS_TWO   = 8'h04;
    localparam logic [7:0] ADDR_STATUS_THREE = 8'h08;
    localparam logic [7:0] ADDR_BREAK_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_BREAK_CTRL   = 8'h10;
    localparam logic [7:0] ADDR_OPTION       = 8'h14;
    localparam logic [7:0] ADDR_CPU_STATE    = 8'h18;

    // Field positions
    localparam int BIT_WAIT_EXIT   = 1;
    localparam int BIT_CLEAR_EN    = 0;
    localparam int BIT_SHORT_REC   = 0;
    localparam int BIT_WDOG_DIS    = 1;

    // Reset values
    localparam logic       RST_CLEAR_EN  = 1'b0;
    localparam logic       RST_SHORT_REC = 1'b0;
    localparam logic       RST_WDOG_DIS  = 1'b0;

    // Stop recovery, counted in crystal clock cycles
    localparam int          CNT_W           = 13;
    localparam logic [12:0] REC_LONG_CYC    = 13'h1000;
    localparam logic [12:0] REC_SHORT_CYC   = 13'h0020;

    // Vector select codes: 0 reset, 1 software, n for source n
    localparam logic [4:0] VEC_RESET    = 5'h00;
    localparam logic [4:0] VEC_SOFTWARE = 5'h01;
    localparam int         NUM_SRC      = 16;

    typedef enum logic [4:0] {
        ST_RUN     = 5'b00001,
        ST_STACK   = 5'b00010,
        ST_WAIT    = 5'b00100,
        ST_STOP    = 5'b01000,
        ST_RECOVER = 5'b10000
    } elpc_state_e;

    // Commands from the CPU core
    typedef struct packed {
        logic inst_done;
        logic swi_exec;
        logic rti_exec;
        logic wait_exec;
        logic stop_exec;
        logic mask_set;
    } elpc_cpu_s;

    // Directions to the CPU core
    typedef struct packed {
        logic       stack_go;
        logic       stack_pc_minus1;
        logic       stack_index_hi;
        logic       unstack_go;
        logic       mask_set;
        logic       mask_clear;
        logic [4:0] vector_sel;
    } elpc_core_s;

endpackage : elpc_pkg

// *** hdl/elpc_exception_ctrl.sv ***
`timescale 1ns/1ps
// Contract
// - Interrupt entry stacks CPU registers and sets the interrupt mask
// - Return from interrupt restores stacked registers and resumes the program
// - Latch and arbitrate at entry; latched request is not preempted
// - Only at instruction end; proceed if mask clear and source enabled
// - Priority: reset, software interrupt, then sources 1..16, 16 lowest
// - Request still pending at return is serviced before next instruction
// - Entry never stacks the high index byte register
// - Software interrupt is taken regardless of the mask bit
// - Software interrupt stacks PC; hardware interrupt stacks PC minus one
// - Read-only per-source flag shows whether its request is present
// - Status one holds flags 6..1 in bits 7..2; status two flags 14..7
// - Status three holds flags 16,15 in bits 1,0; upper bits zero
// - Reset beats every interrupt and is never arbitrated
// - Break request forces a fetch of the software interrupt vector
// - In break, other modules' flags clear only when clear enable is 1
// - Flags cleared in break stay cleared; two-step clears stay protected
// - Wait and stop clear the mask and hold the CPU unclocked
// - Wait: CPU clock off, peripherals run; stack one cycle after wake
// - Wait exits on enabled unmasked interrupt, reset or break; break in wait sets wait-exit flag
// - Watchdog runs through wait mode when its disable bit is 0
// - Stop resets counter, gates CPU, peripheral and crystal clocks; stacking after recovery
// - Counter held in stop, then times 4096 or 32 crystal cycles
// - Recovery counter is 13 bits, advancing each crystal clock cycle
// - Software writing 0 clears the break wait-exit flag
module elpc_exception_ctrl (
    // Clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 reset_n,
    // APB slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic                      pready,
    output logic [31:0]               prdata,
    output logic                      pslverr,
    // Interrupt sources and their enables
    input  wire logic [16:1]          irq_req,
    input  wire logic [16:1]          irq_en,
    input  wire logic                 break_req,
    // CPU core
    input  wire elpc_pkg::elpc_cpu_s  cpu_cmd,
    output elpc_pkg::elpc_core_s      core_ctl,
    output logic                      cpu_clk_en,
    output logic                      periph_clk_en,
    output logic                      xtal_clk_en,
    // Break and watchdog controls
    output logic                      break_active,
    output logic                      flag_clear_allow,
    output logic                      watchdog_run
);

    // Highest-priority source: lowest index wins, 0 when none
    function automatic logic [4:0] pick_source(input logic [16:1] req);
        logic [4:0] sel;
        sel = 5'h00;
        for (int i = 16; i >= 1; i--) begin
            if (req[i]) begin
                sel = 5'(i);
            end
        end
        return sel;
    endfunction : pick_source

    function automatic logic is_addr(input logic [7:0] a, input logic [7:0] ref_a);
        return a == ref_a;
    endfunction : is_addr

    elpc_pkg::elpc_state_e state_r, state_nxt;
    logic                  mask_r, mask_nxt;
    logic [4:0]            latch_vec_r, latch_vec_nxt;
    logic                  latch_hw_r, latch_hw_nxt;
    logic                  latched_r, latched_nxt;
    logic [12:0]           cnt_r, cnt_nxt;
    logic                  in_break_r, in_break_nxt;
    logic                  wait_exit_r, wait_exit_nxt;
    logic                  clear_en_r, clear_en_nxt;
    logic                  short_rec_r, short_rec_nxt;
    logic                  wdog_dis_r, wdog_dis_nxt;
    elpc_pkg::elpc_core_s  ctl_nxt;
    logic                  cpu_en_nxt, per_en_nxt, xtal_en_nxt;
    logic [31:0]           rdata_nxt;
    logic                  rdy_nxt, err_nxt;

    logic [16:1] live_req;
    logic        access;
    logic        wr_take;
    logic        wr_hit_status;
    logic [12:0] rec_target;

    // A source counts only while its enable is set
    assign live_req   = irq_req & irq_en;
    assign access     = psel & penable & ~pready;
    assign wr_take    = psel & penable & pready & pwrite;
    assign rec_target = short_rec_r ? elpc_pkg::REC_SHORT_CYC
                                    : elpc_pkg::REC_LONG_CYC;
    assign wr_hit_status = wr_take
                         & is_addr(paddr, elpc_pkg::ADDR_BREAK_STATUS);

    // Sequencer
    always_comb begin
        state_nxt     = state_r;
        mask_nxt      = mask_r;
        latch_vec_nxt = latch_vec_r;
        latch_hw_nxt  = latch_hw_r;
        latched_nxt   = latched_r;
        cnt_nxt       = cnt_r;
        in_break_nxt  = in_break_r;
        wait_exit_nxt = wait_exit_r;
        ctl_nxt       = '0;
        cpu_en_nxt    = 1'b1;
        per_en_nxt    = 1'b1;
        xtal_en_nxt   = 1'b1;
        // Clearing by software write of 0; a break-in-wait set below wins
        if (wr_hit_status && !pwdata[elpc_pkg::BIT_WAIT_EXIT]) begin
            wait_exit_nxt = 1'b0;
        end
        if (cpu_cmd.mask_set) begin
            mask_nxt = 1'b1;
        end
        unique case (state_r)
            elpc_pkg::ST_RUN: begin
                if (break_req && !in_break_r) begin
                    latch_vec_nxt = elpc_pkg::VEC_SOFTWARE;
                    latch_hw_nxt  = 1'b0;
                    latched_nxt   = 1'b1;
                    in_break_nxt  = 1'b1;
                    state_nxt     = elpc_pkg::ST_STACK;
                end else if (cpu_cmd.swi_exec) begin
                    latch_vec_nxt = elpc_pkg::VEC_SOFTWARE;
                    latch_hw_nxt  = 1'b0;
                    latched_nxt   = 1'b1;
                    state_nxt     = elpc_pkg::ST_STACK;
                end else if (cpu_cmd.rti_exec) begin
                    ctl_nxt.unstack_go = 1'b1;
                    ctl_nxt.mask_clear = 1'b1;
                    mask_nxt           = 1'b0;
                    in_break_nxt       = 1'b0;
                    // Pending request is taken next, before the next opcode
                    if (live_req != '0) begin
                        latch_vec_nxt = pick_source(live_req);
                        latch_hw_nxt  = 1'b1;
                        latched_nxt   = 1'b1;
                        state_nxt     = elpc_pkg::ST_STACK;
                    end
                end else if (cpu_cmd.wait_exec) begin
                    mask_nxt           = 1'b0;
                    ctl_nxt.mask_clear = 1'b1;
                    cpu_en_nxt         = 1'b0;
                    state_nxt          = elpc_pkg::ST_WAIT;
                end else if (cpu_cmd.stop_exec) begin
                    mask_nxt           = 1'b0;
                    ctl_nxt.mask_clear = 1'b1;
                    cpu_en_nxt         = 1'b0;
                    per_en_nxt         = 1'b0;
                    xtal_en_nxt        = 1'b0;
                    cnt_nxt            = '0;
                    state_nxt          = elpc_pkg::ST_STOP;
                end else if (cpu_cmd.inst_done && !mask_r && live_req != '0) begin
                    latch_vec_nxt = pick_source(live_req);
                    latch_hw_nxt  = 1'b1;
                    latched_nxt   = 1'b1;
                    state_nxt     = elpc_pkg::ST_STACK;
                end
            end
            elpc_pkg::ST_STACK: begin
                // Latched vector is held; later requests wait their turn
                ctl_nxt.stack_go        = 1'b1;
                ctl_nxt.stack_pc_minus1 = latch_hw_r;
                ctl_nxt.stack_index_hi  = 1'b0;
                ctl_nxt.mask_set        = 1'b1;
                ctl_nxt.vector_sel      = latch_vec_r;
                mask_nxt                = 1'b1;
                latched_nxt             = 1'b0;
                state_nxt               = elpc_pkg::ST_RUN;
            end
            elpc_pkg::ST_WAIT: begin
                cpu_en_nxt = 1'b0;
                if (break_req) begin
                    wait_exit_nxt = 1'b1;
                    in_break_nxt  = 1'b1;
                    latch_vec_nxt = elpc_pkg::VEC_SOFTWARE;
                    latch_hw_nxt  = 1'b0;
                    latched_nxt   = 1'b1;
                    cpu_en_nxt    = 1'b1;
                    state_nxt     = elpc_pkg::ST_STACK;
                end else if (live_req != '0 && !mask_r) begin
                    latch_vec_nxt = pick_source(live_req);
                    latch_hw_nxt  = 1'b1;
                    latched_nxt   = 1'b1;
                    cpu_en_nxt    = 1'b1;
                    state_nxt     = elpc_pkg::ST_STACK;
                end
            end
            elpc_pkg::ST_STOP: begin
                cpu_en_nxt  = 1'b0;
                per_en_nxt  = 1'b0;
                xtal_en_nxt = 1'b0;
                cnt_nxt     = '0;
                if (break_req) begin
                    in_break_nxt  = 1'b1;
                    latch_vec_nxt = elpc_pkg::VEC_SOFTWARE;
                    latch_hw_nxt  = 1'b0;
                    latched_nxt   = 1'b1;
                    xtal_en_nxt   = 1'b1;
                    state_nxt     = elpc_pkg::ST_RECOVER;
                end else if (live_req != '0 && !mask_r) begin
                    latch_vec_nxt = pick_source(live_req);
                    latch_hw_nxt  = 1'b1;
                    latched_nxt   = 1'b1;
                    xtal_en_nxt   = 1'b1;
                    state_nxt     = elpc_pkg::ST_RECOVER;
                end
            end
            elpc_pkg::ST_RECOVER: begin
                // Oscillator settles while the CPU stays parked
                cpu_en_nxt = 1'b0;
                per_en_nxt = 1'b0;
                cnt_nxt    = 13'(cnt_r + 13'h0001);
                if (cnt_nxt >= rec_target) begin
                    cpu_en_nxt = 1'b1;
                    per_en_nxt = 1'b1;
                    state_nxt  = elpc_pkg::ST_STACK;
                end
            end
            default: begin
                state_nxt = elpc_pkg::ST_RUN;
            end
        endcase
    end

    // Register file
    always_comb begin
        clear_en_nxt  = clear_en_r;
        short_rec_nxt = short_rec_r;
        wdog_dis_nxt  = wdog_dis_r;
        rdata_nxt     = '0;
        rdy_nxt       = access;
        err_nxt       = 1'b0;
        if (access) begin
            unique case (paddr)
                elpc_pkg::ADDR_STATUS_ONE:
                    rdata_nxt[7:2] = irq_req[6:1];
                elpc_pkg::ADDR_STATUS_TWO:
                    rdata_nxt[7:0] = irq_req[14:7];
                elpc_pkg::ADDR_STATUS_THREE:
                    rdata_nxt[1:0] = irq_req[16:15];
                elpc_pkg::ADDR_BREAK_STATUS:
                    rdata_nxt[elpc_pkg::BIT_WAIT_EXIT] = wait_exit_r;
                elpc_pkg::ADDR_BREAK_CTRL:
                    rdata_nxt[elpc_pkg::BIT_CLEAR_EN] = clear_en_r;
                elpc_pkg::ADDR_OPTION: begin
                    rdata_nxt[elpc_pkg::BIT_SHORT_REC] = short_rec_r;
                    rdata_nxt[elpc_pkg::BIT_WDOG_DIS]  = wdog_dis_r;
                end
                elpc_pkg::ADDR_CPU_STATE:
                    rdata_nxt[7:0] = {mask_r, in_break_r, latched_r, state_r};
                default:
                    err_nxt = 1'b1;
            endcase
            if (pwrite) begin
                rdata_nxt = '0;
            end
        end
        // Writes land on the edge that ends the access phase, where the master samples pready
        if (wr_take && is_addr(paddr, elpc_pkg::ADDR_BREAK_CTRL)) begin
            clear_en_nxt = pwdata[elpc_pkg::BIT_CLEAR_EN];
        end
        if (wr_take && is_addr(paddr, elpc_pkg::ADDR_OPTION)) begin
            short_rec_nxt = pwdata[elpc_pkg::BIT_SHORT_REC];
            wdog_dis_nxt  = pwdata[elpc_pkg::BIT_WDOG_DIS];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            // Reset overrides all arbitration and parks at run
            state_r       <= elpc_pkg::ST_RUN;
            mask_r        <= 1'b1;
            latch_vec_r   <= elpc_pkg::VEC_RESET;
            latch_hw_r    <= 1'b0;
            latched_r     <= 1'b0;
            cnt_r         <= '0;
            in_break_r    <= 1'b0;
            wait_exit_r   <= 1'b0;
            clear_en_r    <= elpc_pkg::RST_CLEAR_EN;
            short_rec_r   <= elpc_pkg::RST_SHORT_REC;
            wdog_dis_r    <= elpc_pkg::RST_WDOG_DIS;
            core_ctl      <= '0;
            cpu_clk_en    <= 1'b1;
            periph_clk_en <= 1'b1;
            xtal_clk_en   <= 1'b1;
            pready        <= 1'b0;
            prdata        <= '0;
            pslverr       <= 1'b0;
            break_active     <= 1'b0;
            flag_clear_allow <= 1'b1;
            watchdog_run     <= 1'b1;
        end else begin
            state_r       <= state_nxt;
            mask_r        <= mask_nxt;
            latch_vec_r   <= latch_vec_nxt;
            latch_hw_r    <= latch_hw_nxt;
            latched_r     <= latched_nxt;
            cnt_r         <= cnt_nxt;
            in_break_r    <= in_break_nxt;
            wait_exit_r   <= wait_exit_nxt;
            clear_en_r    <= clear_en_nxt;
            short_rec_r   <= short_rec_nxt;
            wdog_dis_r    <= wdog_dis_nxt;
            core_ctl      <= ctl_nxt;
            cpu_clk_en    <= cpu_en_nxt;
            periph_clk_en <= per_en_nxt;
            xtal_clk_en   <= xtal_en_nxt;
            pready        <= rdy_nxt;
            prdata        <= rdata_nxt;
            pslverr       <= err_nxt;
            break_active     <= in_break_nxt;
            // Modules hold both clear steps while this is low
            flag_clear_allow <= !in_break_nxt || clear_en_nxt;
            // Watchdog keeps running in wait unless disabled
            watchdog_run     <= !wdog_dis_nxt && (state_nxt != elpc_pkg::ST_STOP);
        end
    end

endmodule : elpc_exception_ctrl

// *** testbench/elpc_cpu_model.sv ***
`timescale 1ns/1ps
module elpc_cpu_model (
    // Clock
    input  wire logic                 core_clk,
    // Exception unit side
    output elpc_pkg::elpc_cpu_s       cpu_cmd,
    input  wire elpc_pkg::elpc_core_s core_ctl
);
    initial cpu_cmd = '0;

    // One-cycle command pulse, dropped at the edge that samples it
    task send(input logic [5:0] c);
        @(posedge core_clk);
        cpu_cmd <= elpc_pkg::elpc_cpu_s'(c);
        @(posedge core_clk);
        cpu_cmd <= '0;
    endtask : send

    // Bounded wait for an entry; the vector and stacking kind travel with it
    task await_stack(output logic got, output logic [4:0] vec, output logic pcm);
        got = 1'b0;
        vec = 5'h1f;
        pcm = 1'b0;
        for (int i = 0; i < 12 && !got; i++) begin
            @(posedge core_clk);
            if (core_ctl.stack_go === 1'b1) begin
                got = 1'b1;
                vec = core_ctl.vector_sel;
                pcm = core_ctl.stack_pc_minus1;
            end
        end
    endtask : await_stack
endmodule : elpc_cpu_model

// *** testbench/elpc_exception_ctrl_properties.sv ***
`timescale 1ns/1ps
module elpc_properties (
    // Clock and reset
    input wire logic                 core_clk,
    input wire logic                 reset_n,
    // APB
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [7:0]           paddr,
    input wire logic                 pready,
    input wire logic [31:0]          prdata,
    // Requests and core
    input wire logic [16:1]          irq_req,
    input wire logic                 break_req,
    input wire elpc_pkg::elpc_cpu_s  cpu_cmd,
    input wire elpc_pkg::elpc_core_s core_ctl,
    input wire logic                 cpu_clk_en,
    input wire logic                 periph_clk_en,
    input wire logic                 xtal_clk_en,
    input wire logic                 break_active,
    input wire logic                 flag_clear_allow
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    logic rd_take;
    logic run_ok;
    assign rd_take = psel && penable && !pready && !pwrite;
    // Only a quiet run cycle; higher-priority commands would win instead
    assign run_ok  = cpu_clk_en && !core_ctl.stack_go && !break_req
                     && !cpu_cmd.swi_exec && !cpu_cmd.rti_exec;

    property p_index_hi; !core_ctl.stack_index_hi; endproperty
    a_index_hi: assert property (p_index_hi) else $error("index byte stacked");
    property p_mask_entry; core_ctl.stack_go |-> core_ctl.mask_set; endproperty
    a_mask_entry: assert property (p_mask_entry) else $error("entry without mask");
    property p_pc_kind;
        core_ctl.stack_go && !core_ctl.stack_pc_minus1
            |-> core_ctl.vector_sel == elpc_pkg::VEC_SOFTWARE;
    endproperty
    a_pc_kind: assert property (p_pc_kind) else $error("hardware entry stacked pc");
    property p_stat_one;
        rd_take && paddr == elpc_pkg::ADDR_STATUS_ONE
            |=> prdata == {24'h0, $past(irq_req[6:1]), 2'b00};
    endproperty
    a_stat_one: assert property (p_stat_one) else $error("status one layout");
    property p_stat_three;
        rd_take && paddr == elpc_pkg::ADDR_STATUS_THREE
            |=> prdata == {30'h0, $past(irq_req[16:15])};
    endproperty
    a_stat_three: assert property (p_stat_three) else $error("status three layout");
    property p_wait_gate; run_ok && cpu_cmd.wait_exec |=> !cpu_clk_en; endproperty
    a_wait_gate: assert property (p_wait_gate) else $error("cpu clock runs in wait");
    property p_stop_gate;
        run_ok && cpu_cmd.stop_exec && !cpu_cmd.wait_exec
            |-> ##[1:2] (!cpu_clk_en && !periph_clk_en && !xtal_clk_en);
    endproperty
    a_stop_gate: assert property (p_stop_gate) else $error("clocks run in stop");
    property p_clear_out; !break_active |-> flag_clear_allow; endproperty
    a_clear_out: assert property (p_clear_out) else $error("flags locked outside break");
    property p_break_vec;
        $rose(break_req) && cpu_clk_en && !break_active
            |-> ##[1:4] (core_ctl.stack_go && core_ctl.vector_sel == elpc_pkg::VEC_SOFTWARE);
    endproperty
    a_break_vec: assert property (p_break_vec) else $error("break vector missing");
endmodule : elpc_properties

bind elpc_exception_ctrl elpc_properties u_props (
    .core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata),
    .irq_req(irq_req), .break_req(break_req), .cpu_cmd(cpu_cmd), .core_ctl(core_ctl),
    .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .xtal_clk_en(xtal_clk_en),
    .break_active(break_active), .flag_clear_allow(flag_clear_allow)
);

// *** testbench/exception_and_low_power_control_bench.sv ***
`timescale 1ns/1ps
module exception_and_low_power_control_bench;
    localparam logic [5:0] C_DONE = 6'h20, C_SWI = 6'h10, C_RTI = 6'h08;
    localparam logic [5:0] C_WAIT = 6'h04, C_STOP = 6'h02;
    logic core_clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [16:1] irq_req = 16'h0000, irq_en = 16'h0000;
    logic        break_req = 1'b0, pready, pslverr, er, got, pcm;
    logic        cpu_clk_en, periph_clk_en, xtal_clk_en, break_active, flag_clear_allow;
    logic        watchdog_run;
    logic [4:0]  vec;
    elpc_pkg::elpc_cpu_s  cpu_cmd;
    elpc_pkg::elpc_core_s core_ctl;
    int errors = 0, check_count = 0, n;

    always #50 core_clk = ~core_clk;

    elpc_exception_ctrl dut (
        .core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .irq_req(irq_req), .irq_en(irq_en), .break_req(break_req),
        .cpu_cmd(cpu_cmd), .core_ctl(core_ctl), .cpu_clk_en(cpu_clk_en),
        .periph_clk_en(periph_clk_en), .xtal_clk_en(xtal_clk_en),
        .break_active(break_active), .flag_clear_allow(flag_clear_allow),
        .watchdog_run(watchdog_run)
    );
    elpc_cpu_model u_cpu (.core_clk(core_clk), .cpu_cmd(cpu_cmd), .core_ctl(core_ctl));

    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge core_clk); n++; end while (pready !== 1'b1 && n < 20);
        check("apb answer", pready, 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    task t_regs;
        apb(0, elpc_pkg::ADDR_BREAK_CTRL, 0); check("clear enable reset", rd, 0);
        apb(0, elpc_pkg::ADDR_OPTION, 0); check("option reset", rd, 0);
        apb(0, 8'h1c, 0); check("unmapped error", er, 1); check("unmapped data", rd, 0);
        apb(1, elpc_pkg::ADDR_STATUS_ONE, 32'hff); apb(0, elpc_pkg::ADDR_STATUS_ONE, 0);
        check("status read only", rd, 0);
    endtask : t_regs

    task t_flags;
        logic [16:1] p;
        p = 16'ha5c3;
        irq_req <= p;
        apb(0, elpc_pkg::ADDR_STATUS_ONE, 0);
        check("status one", rd, {24'h0, p[6:1], 2'b00});
        apb(0, elpc_pkg::ADDR_STATUS_TWO, 0); check("status two", rd, {24'h0, p[14:7]});
        apb(0, elpc_pkg::ADDR_STATUS_THREE, 0);
        check("status three", rd, {30'h0, p[16:15]});
        irq_req <= 16'h0000;
    endtask : t_flags

    task t_swi;
        irq_req <= 16'h0002; irq_en <= 16'h0002;
        u_cpu.send(C_DONE); u_cpu.await_stack(got, vec, pcm); check("masked entry", got, 0);
        irq_req <= 16'h0000; irq_en <= 16'h0000;
        u_cpu.send(C_SWI); u_cpu.await_stack(got, vec, pcm);
        check("swi taken", got, 1);
        check("swi vector", vec, elpc_pkg::VEC_SOFTWARE);
        check("swi stacks pc", pcm, 0);
        u_cpu.send(C_RTI);
        @(posedge core_clk);
        check("unstack on return", core_ctl.unstack_go, 1);
        check("mask clear on return", core_ctl.mask_clear, 1);
    endtask : t_swi

    task t_wait_irq;
        u_cpu.send(C_WAIT); repeat (2) @(posedge core_clk);
        check("cpu clock in wait", cpu_clk_en, 0);
        check("periph clock in wait", periph_clk_en, 1);
        check("watchdog in wait", watchdog_run, 1);
        irq_req <= 16'h0105; irq_en <= 16'h0104;
        u_cpu.await_stack(got, vec, pcm);
        check("wake entry", got, 1);
        check("priority vector", vec, 5'h03);
        check("hw stacks pc minus one", pcm, 1);
        irq_req <= 16'h0101;
        u_cpu.send(C_DONE); u_cpu.await_stack(got, vec, pcm); check("no preempt", got, 0);
        u_cpu.send(C_RTI); u_cpu.await_stack(got, vec, pcm);
        if (!got) begin u_cpu.send(C_DONE); u_cpu.await_stack(got, vec, pcm); end
        check("pending after return", got, 1);
        check("pending vector", vec, 5'h09);
        irq_req <= 16'h0000; irq_en <= 16'h0000;
        u_cpu.send(C_RTI);
    endtask : t_wait_irq

    task t_break;
        apb(1, elpc_pkg::ADDR_BREAK_CTRL, 0);
        break_req <= 1'b1; u_cpu.await_stack(got, vec, pcm); break_req <= 1'b0;
        check("break vector", vec, elpc_pkg::VEC_SOFTWARE);
        check("break active", break_active, 1);
        check("flags locked", flag_clear_allow, 0);
        apb(1, elpc_pkg::ADDR_BREAK_CTRL, 1); repeat (2) @(posedge core_clk);
        check("flags clearable", flag_clear_allow, 1);
        apb(1, elpc_pkg::ADDR_BREAK_CTRL, 0);
        u_cpu.send(C_RTI); repeat (2) @(posedge core_clk);
        check("break ended", break_active, 0);
        check("clear after break", flag_clear_allow, 1);
    endtask : t_break

    task t_wait_break;
        u_cpu.send(C_WAIT); repeat (2) @(posedge core_clk);
        break_req <= 1'b1; u_cpu.await_stack(got, vec, pcm); break_req <= 1'b0;
        check("break leaves wait", got, 1);
        apb(0, elpc_pkg::ADDR_BREAK_STATUS, 0);
        check("wait exit flag", rd[elpc_pkg::BIT_WAIT_EXIT], 1);
        apb(1, elpc_pkg::ADDR_BREAK_STATUS, 0); apb(0, elpc_pkg::ADDR_BREAK_STATUS, 0);
        check("wait exit cleared", rd[elpc_pkg::BIT_WAIT_EXIT], 0);
        u_cpu.send(C_RTI);
    endtask : t_wait_break

    task t_stop(input logic sh);
        int r;
        r = sh ? int'(elpc_pkg::REC_SHORT_CYC) : int'(elpc_pkg::REC_LONG_CYC);
        apb(1, elpc_pkg::ADDR_OPTION, {31'h0, sh});
        u_cpu.send(C_STOP); repeat (2) @(posedge core_clk);
        check("stop clocks", {cpu_clk_en, periph_clk_en, xtal_clk_en}, 0);
        irq_req <= 16'h0004; irq_en <= 16'h0004;
        n = 0;
        while (core_ctl.stack_go !== 1'b1 && n < 5000) begin @(posedge core_clk); n++; end
        check("recovery length", n >= r && n <= r + 6, 1);
        irq_req <= 16'h0000; irq_en <= 16'h0000;
        u_cpu.send(C_RTI);
    endtask : t_stop

    task finish_test;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : finish_test

    // Longest path is the full stop recovery; the margin covers all the rest
    initial begin
        #(20000 * 100);
        errors++;
        finish_test;
    end

    initial begin
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        t_regs; t_flags; t_swi; t_wait_irq; t_break; t_wait_break;
        t_stop(1'b1); t_stop(1'b0);
        finish_test;
    end
endmodule : exception_and_low_power_control_bench
